// file: fhd_pkg.sv
// Constants for the full-handshake receive side: host port and DMA channel.
// Assumes one core clock; phases T0..T3 are derived from it.
package fhd_pkg;
    localparam logic [5:0]  TX_WORD_OFFSET   = 6'h28;
    localparam logic [3:0]  REG_SEL_TX       = 4'h0A;
    localparam int          WORD_W           = 32;
    localparam int          ADDR_W           = 8;
    localparam int          CNT_W            = 16;
    localparam int          MASK_W           = 7;
    localparam logic [6:0]  MASK_RX_FULL     = 7'h08;
    localparam logic [1:0]  PH_T0            = 2'h0;
    localparam logic [1:0]  PH_T1            = 2'h1;
    localparam logic [1:0]  PH_T2            = 2'h2;
    localparam logic [1:0]  PH_T3            = 2'h3;
    localparam int          PHASES           = 4;
    localparam logic [6:0]  MASK_RESET       = 7'h00;
    localparam logic [15:0] COUNT_RESET      = 16'h0000;
    localparam logic [7:0]  ADDR_RESET       = 8'h00;
    localparam logic [7:0]  SRC_OFFSET_RESET = 8'h00;
    localparam int          DEPTH            = 256;
    typedef enum logic [1:0] {
        CH_IDLE = 2'b00,
        CH_ADDR = 2'b01,
        CH_READ = 2'b10,
        CH_DONE = 2'b11
    } fhd_ch_e;
endpackage

// file: fhd_mem.sv
// Internal word memory written by the receive DMA channel.
// Assumes a single core clock; read data come out of a register.
`timescale 1ns/10ps
module fhd_mem (
    // Clock
    input  wire logic                          core_clk,
    // Write port
    input  wire logic                          wr_en,
    input  wire logic [fhd_pkg::ADDR_W-1:0]    wr_addr,
    input  wire logic [fhd_pkg::WORD_W-1:0]    wr_data,
    // Read port
    input  wire logic [fhd_pkg::ADDR_W-1:0]    rd_addr,
    output logic      [fhd_pkg::WORD_W-1:0]    rd_data
);
    logic [fhd_pkg::WORD_W-1:0] mem [fhd_pkg::DEPTH];

    always_ff @(posedge core_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule

// file: fhd_rx.sv
// Receive end of a full-handshake word DMA: host port, holding register,
// and a single-block word-transfer DMA channel into internal memory.
// Assumes the sender drives select, rd/wr and strobe asynchronously.
//
// Notes on behaviour
// - Channel triggers per word on receive full
// - Transmit empty drives request once enabled
// - Capture word at strobe trailing edge
// - Write clears empty, drops request, moves word
// - Request after holding register filled, flag updated
// - Read clears full, request reasserts
// - End interrupt when enabled, block done
// - Slave mode; no wait states; clocks independent
// - Source fixed at holding register, counter length
// - Mask value selects receive full source
// - Four phases per instruction cycle
// - Request armed on T0 (t1 decodes PH_T0) after init
// - Empty clears T0, load on T2 (t3 decodes PH_T2), pulse next clock
// - Address next T0, read following T0
// - Word takes at least eight clocks
`timescale 1ns/10ps
module fhd_rx (
    // Clock and reset
    input  wire logic                        core_clk,
    input  wire logic                        rstn,
    // Host bus from the sender
    input  wire logic                        host_select_n,
    input  wire logic                        read_not_write,
    input  wire logic                        transfer_strobe_n,
    input  wire logic [3:0]                  reg_addr,
    input  wire logic [fhd_pkg::WORD_W-1:0]  host_data_in,
    input  wire logic                        bus_grant_tie,
    // Host request to the sender
    output logic                             host_request_line_n,
    // Channel programming
    input  wire logic                        ch_enable,
    input  wire logic                        end_interrupt_enable,
    input  wire logic [fhd_pkg::MASK_W-1:0]  request_mask_bits,
    input  wire logic [fhd_pkg::ADDR_W-1:0]  dest_start,
    input  wire logic [fhd_pkg::CNT_W-1:0]   block_length,
    input  wire logic [fhd_pkg::ADDR_W-1:0]  src_offset,
    // Memory readout and status
    input  wire logic [fhd_pkg::ADDR_W-1:0]  mem_rd_addr,
    output logic      [fhd_pkg::WORD_W-1:0]  mem_rd_data,
    output logic                             receive_full_flag,
    output logic                             transmit_empty_flag,
    output logic                             holding_load_pulse,
    output logic                             dma_done_irq,
    output logic      [fhd_pkg::CNT_W-1:0]   words_left
);
    logic [2:0]                 strb_sync_reg;
    logic [2:0]                 sel_sync_reg;
    logic [2:0]                 rw_sync_reg;
    logic [2:0][3:0]            addr_sync_reg;
    logic [2:0][fhd_pkg::WORD_W-1:0] data_sync_reg;
    logic                       strb_stable_reg;
    logic                       sel_stable_reg;
    logic                       rw_stable_reg;
    logic [1:0]                 phase_reg;
    logic [fhd_pkg::WORD_W-1:0] tx_word_reg;
    logic [fhd_pkg::WORD_W-1:0] hold_reg;
    logic                       tx_written_reg;
    logic                       load_due_reg;
    logic                       en_d_reg;
    logic                       armed_reg;
    logic [fhd_pkg::ADDR_W-1:0] dest_reg;
    logic [fhd_pkg::WORD_W-1:0] wdata_reg;
    logic                       wen_reg;
    fhd_pkg::fhd_ch_e           ch_reg;
    logic                       strb_trail;
    logic                       tx_hit;
    logic                       cfg_ok;
    logic                       t0;
    logic                       t3;
    logic                       t1;
    logic                       move_start;
    logic                       load_now;
    logic                       ch_start;
    logic                       ch_trigger;
    logic                       rd_step;

    assign t0 = (phase_reg == fhd_pkg::PH_T0);
    assign t1 = (phase_reg == fhd_pkg::PH_T0);
    assign t3 = (phase_reg == fhd_pkg::PH_T2);

    // Three-stage pin synchronisers
    always_ff @(posedge core_clk) begin
        strb_sync_reg <= {strb_sync_reg[1:0], transfer_strobe_n};
        sel_sync_reg  <= {sel_sync_reg[1:0], host_select_n};
        rw_sync_reg   <= {rw_sync_reg[1:0], read_not_write};
        addr_sync_reg <= {addr_sync_reg[1:0], reg_addr};
        data_sync_reg <= {data_sync_reg[1:0], host_data_in};
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            strb_stable_reg <= 1'b1;
            sel_stable_reg  <= 1'b1;
            rw_stable_reg   <= 1'b1;
        end else begin
            if (strb_sync_reg[2] == strb_sync_reg[1]) begin
                strb_stable_reg <= strb_sync_reg[2];
            end
            if (sel_sync_reg[2] == sel_sync_reg[1]) begin
                sel_stable_reg <= sel_sync_reg[2];
            end
            if (rw_sync_reg[2] == rw_sync_reg[1]) begin
                rw_stable_reg <= rw_sync_reg[2];
            end
        end
    end

    assign strb_trail = !strb_stable_reg && (strb_sync_reg[2] == 1'b1)
                        && (strb_sync_reg[1] == 1'b1);
    // slave only with grant tied high
    assign tx_hit = strb_trail && !sel_stable_reg && !rw_stable_reg
                    && bus_grant_tie
                    && (addr_sync_reg[2] == fhd_pkg::REG_SEL_TX)
                    && (addr_sync_reg[1] == fhd_pkg::REG_SEL_TX);

    // two phases per clock, four per cycle
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            phase_reg <= fhd_pkg::PH_T0;
        end else begin
            phase_reg <= phase_reg + fhd_pkg::PH_T2;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            tx_word_reg <= '0;
        end else if (tx_hit) begin
            tx_word_reg <= data_sync_reg[2];
        end
    end

    assign move_start = tx_written_reg && t0 && !tx_hit;
    assign load_now   = load_due_reg && t3 && !receive_full_flag;

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            tx_written_reg <= 1'b0;
        end else if (tx_hit) begin
            tx_written_reg <= 1'b1;
        end else if (move_start) begin
            tx_written_reg <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            load_due_reg <= 1'b0;
        end else if (move_start) begin
            load_due_reg <= 1'b1;
        end else if (load_now) begin
            load_due_reg <= 1'b0;
        end
    end

    // empty clears on T0, sets at load
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            transmit_empty_flag <= 1'b1;
        end else if (move_start) begin
            transmit_empty_flag <= 1'b0;
        end else if (load_now) begin
            transmit_empty_flag <= 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            holding_load_pulse <= 1'b0;
        end else begin
            holding_load_pulse <= load_now;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            hold_reg          <= '0;
            receive_full_flag <= 1'b0;
        end else begin
            if (holding_load_pulse) begin
                hold_reg          <= tx_word_reg;
                receive_full_flag <= 1'b1;
            end else if (rd_step) begin
                receive_full_flag <= 1'b0;
            end
        end
    end

    assign cfg_ok = (request_mask_bits == fhd_pkg::MASK_RX_FULL)
                    && (src_offset == fhd_pkg::SRC_OFFSET_RESET);

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            host_request_line_n <= 1'b1;
            armed_reg           <= 1'b0;
        end else begin
            if (ch_enable && !armed_reg && t1) begin
                armed_reg <= 1'b1;
            end else if (!ch_enable) begin
                armed_reg <= 1'b0;
            end
            host_request_line_n <= !(ch_enable && armed_reg
                                     && transmit_empty_flag
                                     && !receive_full_flag
                                     && !tx_written_reg && !load_due_reg);
        end
    end

    assign ch_start   = ch_enable && !en_d_reg;
    assign rd_step    = (ch_reg == fhd_pkg::CH_READ) && t0 && !ch_start;
    assign ch_trigger = ch_enable && cfg_ok && receive_full_flag
                        && (words_left != fhd_pkg::COUNT_RESET) && t1;

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            en_d_reg <= 1'b0;
        end else begin
            en_d_reg <= ch_enable;
        end
    end

    // address on T0, read on next T0
    // at least eight clocks per word
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            ch_reg <= fhd_pkg::CH_IDLE;
        end else if (ch_start) begin
            ch_reg <= fhd_pkg::CH_IDLE;
        end else begin
            unique case (ch_reg)
                fhd_pkg::CH_IDLE: begin
                    if (ch_trigger) begin
                        ch_reg <= fhd_pkg::CH_ADDR;
                    end
                end
                fhd_pkg::CH_ADDR: begin
                    if (t0) begin
                        ch_reg <= fhd_pkg::CH_READ;
                    end
                end
                fhd_pkg::CH_READ: begin
                    if (t0) begin
                        ch_reg <= (words_left == 16'h0001)
                                  ? fhd_pkg::CH_DONE
                                  : fhd_pkg::CH_IDLE;
                    end
                end
                fhd_pkg::CH_DONE: begin
                    ch_reg <= fhd_pkg::CH_DONE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            words_left <= fhd_pkg::COUNT_RESET;
        end else if (ch_start) begin
            words_left <= block_length;
        end else if (rd_step) begin
            words_left <= words_left - 16'h0001;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            wen_reg   <= 1'b0;
            wdata_reg <= '0;
        end else begin
            wen_reg   <= rd_step;
            wdata_reg <= hold_reg;
        end
    end

    // Destination steps per stored word
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            dest_reg <= fhd_pkg::ADDR_RESET;
        end else if (ch_start) begin
            dest_reg <= dest_start;
        end else if (wen_reg) begin
            dest_reg <= dest_reg + 8'h01;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            dma_done_irq <= 1'b0;
        end else if (ch_start) begin
            dma_done_irq <= 1'b0;
        end else if (ch_reg == fhd_pkg::CH_DONE) begin
            dma_done_irq <= end_interrupt_enable;
        end
    end

    fhd_mem u_mem (
        .core_clk (core_clk),
        .wr_en    (wen_reg),
        .wr_addr  (dest_reg),
        .wr_data  (wdata_reg),
        .rd_addr  (mem_rd_addr),
        .rd_data  (mem_rd_data)
    );
endmodule

// file: fhd_rx_checker.sv
// Port checker for the receive end of the word handshake.
// Assumes one core clock and the synchronous active-low reset.
`timescale 1ns/10ps
module fhd_rx_checker (
    // Clock and reset
    input wire logic                       core_clk,
    input wire logic                       rstn,
    // Programming inputs
    input wire logic                       bus_grant_tie,
    input wire logic                       ch_enable,
    input wire logic                       end_interrupt_enable,
    input wire logic [fhd_pkg::MASK_W-1:0] request_mask_bits,
    input wire logic [fhd_pkg::ADDR_W-1:0] src_offset,
    // Status outputs
    input wire logic                       host_request_line_n,
    input wire logic                       receive_full_flag,
    input wire logic                       transmit_empty_flag,
    input wire logic                       holding_load_pulse,
    input wire logic                       dma_done_irq,
    input wire logic [fhd_pkg::CNT_W-1:0]  words_left
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    empty_to_load_a: assert property (
        $fell(transmit_empty_flag) && !receive_full_flag |-> ##1
        holding_load_pulse) else $error("load not on T3 after empty");
    load_sets_empty_a: assert property (
        holding_load_pulse |-> transmit_empty_flag)
        else $error("empty not set at load");
    load_to_full_a: assert property (
        holding_load_pulse |=> receive_full_flag)
        else $error("full not set after load");
    load_gap_a: assert property (
        holding_load_pulse |=> !holding_load_pulse [*7])
        else $error("words closer than eight clocks");
    write_drops_req_a: assert property (
        !transmit_empty_flag |=> host_request_line_n)
        else $error("request active while not empty");
    idle_no_req_a: assert property (
        !ch_enable |=> host_request_line_n)
        else $error("request active while disabled");
    mask_blocks_a: assert property (
        receive_full_flag && request_mask_bits != fhd_pkg::MASK_RX_FULL
        |=> receive_full_flag) else $error("full cleared with wrong mask");
    offset_blocks_a: assert property (
        receive_full_flag && src_offset != 8'h00 |=> receive_full_flag)
        else $error("full cleared with moving source");
    grant_blocks_a: assert property (
        !bus_grant_tie && transmit_empty_flag |=> transmit_empty_flag)
        else $error("write taken with grant low");
    irq_cause_a: assert property (
        $rose(dma_done_irq) |-> end_interrupt_enable && words_left == 0)
        else $error("interrupt without finished block");
    irq_quiet_a: assert property (
        !end_interrupt_enable && !dma_done_irq |=> !dma_done_irq)
        else $error("interrupt while disabled");
endmodule

bind fhd_rx fhd_rx_checker u_fhd_rx_checker (.core_clk, .rstn,
    .bus_grant_tie, .ch_enable, .end_interrupt_enable, .request_mask_bits,
    .src_offset, .host_request_line_n, .receive_full_flag,
    .transmit_empty_flag, .holding_load_pulse, .dma_done_irq, .words_left);

// file: fhd_snd.sv
// Behavioural sending processor: one host write per request.
// Assumes the same core clock; drives at the falling edge.
`timescale 1ns/10ps
module fhd_snd (
    // Clock and control
    input wire logic   core_clk,
    input wire logic   rstn,
    input wire logic   slow,
    input wire logic [7:0] limit,
    input wire logic   req_n,
    // Host bus
    output logic       sel_n = 1'b1,
    output logic       rnw = 1'b1,
    output logic       strobe_n = 1'b1,
    output logic [3:0] reg_addr = 4'h5,
    output logic [31:0] data_out = 32'h0000_0000
);
    logic [7:0] n = 8'h00;
    always begin
        @(negedge core_clk);
        if (!rstn) n = 8'h00;
        if (rstn && !req_n && n < limit) begin
            sel_n = 1'b0;
            rnw = 1'b0;
            reg_addr = 4'hA;
            data_out = 32'hA5A5_0000 + 32'(n);
            strobe_n = 1'b0;
            repeat (slow ? 6 : 2) @(negedge core_clk);
            strobe_n = 1'b1;
            repeat (6) @(negedge core_clk);
            sel_n = 1'b1;
            rnw = 1'b1;
            reg_addr = 4'h5;
            data_out = ~data_out;
            n = n + 8'h01;
            // wait for request to drop first
            while (!req_n && rstn) @(negedge core_clk);
        end
    end
endmodule

// file: tb_full_handshake_dma_transfer.sv
// Self-checking bench for the receive end with a model sender.
// Assumes 40 MHz core clock; inputs change at the falling edge.
`timescale 1ns/10ps
module tb_full_handshake_dma_transfer;
    logic        core_clk = 1'b0;
    logic        rstn = 1'b0;
    logic        sel_n, rnw, strobe_n, req_n, pulse, irq, full, empty;
    logic        grant = 1'b1;
    logic        slow = 1'b0;
    logic        ch_enable = 1'b0;
    logic        ie = 1'b0;
    logic [7:0]  limit = 8'h00;
    logic [6:0]  mask = fhd_pkg::MASK_RX_FULL;
    logic [7:0]  dest = 8'h00;
    logic [7:0]  offs = 8'h00;
    logic [7:0]  rd_addr = 8'h00;
    logic [15:0] len = 16'h0000;
    logic [15:0] words_left;
    logic [3:0]  reg_addr;
    logic [31:0] data, rd_data;
    int          n_fail = 0;
    int          checked = 0;

    fhd_rx u_fhd_rx (.core_clk(core_clk), .rstn(rstn),
        .host_select_n(sel_n), .read_not_write(rnw),
        .transfer_strobe_n(strobe_n), .reg_addr(reg_addr),
        .host_data_in(data), .bus_grant_tie(grant),
        .host_request_line_n(req_n), .ch_enable(ch_enable),
        .end_interrupt_enable(ie), .request_mask_bits(mask),
        .dest_start(dest), .block_length(len), .src_offset(offs),
        .mem_rd_addr(rd_addr), .mem_rd_data(rd_data),
        .receive_full_flag(full), .transmit_empty_flag(empty),
        .holding_load_pulse(pulse), .dma_done_irq(irq),
        .words_left(words_left));
    fhd_snd u_fhd_snd (.core_clk(core_clk), .rstn(rstn), .slow(slow),
        .limit(limit), .req_n(req_n), .sel_n(sel_n), .rnw(rnw),
        .strobe_n(strobe_n), .reg_addr(reg_addr), .data_out(data));

    always #12.5 core_clk = ~core_clk;

    task check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: %h not %h", $time, seen, exp);
        end
    endtask

    task reset_dut;
        rstn = 1'b0;
        ch_enable = 1'b0;
        {mask, offs, grant, limit} = {fhd_pkg::MASK_RX_FULL, 17'h0_0100};
        repeat (12) @(negedge core_clk);
        check(32'({req_n, empty, full, pulse, irq, words_left}),
              32'h0018_0000);
        rstn = 1'b1;
    endtask

    task run_block(input logic [15:0] l, input logic [7:0] d,
                   input logic i_en, input logic sl);
        int i;
        reset_dut();
        {len, dest, ie, slow, limit} = {l, d, i_en, sl, l[7:0]};
        @(negedge core_clk);
        ch_enable = 1'b1;
        repeat (3) @(negedge core_clk);
        check(32'(words_left), 32'(l));
        for (i = 0; i < 20 && req_n !== 1'b0; i++) @(negedge core_clk);
        check(32'(req_n), 32'h0000_0000);
        for (i = 0; i < 800 && words_left !== 16'h0000; i++)
            @(negedge core_clk);
        check(32'(words_left), 32'h0000_0000);
        repeat (6) @(negedge core_clk);
        check(32'(irq), 32'(i_en));
        check(32'(full), 32'h0000_0000);
        for (i = 0; i < 32'(l); i++) begin
            rd_addr = d + 8'(i);
            repeat (2) @(negedge core_clk);
            check(rd_data, 32'hA5A5_0000 + 32'(i));
        end
    endtask

    task run_stuck(input logic [6:0] m, input logic [7:0] o,
                   input logic g);
        reset_dut();
        {mask, offs, grant, len, limit, ie} = {m, o, g, 16'h0001, 9'h3};
        @(negedge core_clk);
        ch_enable = 1'b1;
        repeat (80) @(negedge core_clk);
        check(32'(words_left), 32'h0000_0001);
        check(32'(full), 32'(g));
        check(32'(empty), 32'h0000_0001);
        check(32'(irq), 32'h0000_0000);
    endtask

    task complete_run;
        if (n_fail == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        run_block(16'h0004, 8'h10, 1'b1, 1'b0);
        run_block(16'h0003, 8'hFD, 1'b0, 1'b1);
        run_stuck(7'h01, 8'h00, 1'b1);
        run_stuck(fhd_pkg::MASK_RX_FULL, 8'h04, 1'b1);
        run_stuck(fhd_pkg::MASK_RX_FULL, 8'h00, 1'b0);
        run_block(16'h0001, 8'h00, 1'b1, 1'b0);
        complete_run();
    end

    initial begin
        #500000;
        n_fail++;
        complete_run();
    end
endmodule
